/* File: verilog/dapc_top.sv */
`include "dapc_defines.svh"
module dapc_top
	import dapc_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	// serial link pins from the host
	input  wire logic                   cs_n,
	input  wire logic                   sclk,
	// serial data pins toward the host
	output logic                        serial_out_a,
	output logic                        serial_out_a_oe,
	output logic                        serial_out_b,
	output logic                        serial_out_b_oe,
	// results from the two converters
	input  wire logic                   conv_valid,
	output logic                        conv_ready,
	input  wire logic [`DAPC_RES_W-1:0] converter_a,
	input  wire logic [`DAPC_RES_W-1:0] converter_b,
	// analog control
	output logic                        sample_hold,
	output logic                        conv_start,
	output logic                        powered,
	output logic                        ref_on,
	output logic [2:0]                  mode
);
	typedef struct packed
	{
		logic [2:0]             cs_sync;
		logic [2:0]             sclk_sync;
		logic                   active;
		logic [`DAPC_CNT_W-1:0] falls;
		logic                   track_pend;
		logic                   wake_pend;
		logic                   hold;
		logic                   valid_frame;
		logic [15:0]            sh_a;
		logic [15:0]            sh_b;
		logic [`DAPC_RES_W-1:0] nxt_a;
		logic [`DAPC_RES_W-1:0] nxt_b;
		logic                   oa;
		logic                   ob;
		logic                   oea;
		logic                   oeb;
		logic                   start;
		logic                   pwr;
		logic                   ref_en;
		dapc_mode_t             mode;
	} dapc_st_t;
	dapc_st_t               s_q;
	dapc_st_t               s_d;
	dapc_pair_t             fifo_out;
	dapc_pair_t             fifo_in;
	dapc_pair_t             head;
	logic                   fifo_valid;
	logic                   pop;
	logic                   cs_fall;
	logic                   cs_rise;
	logic                   sclk_fall;
	logic                   sclk_rise;
	// next power mode at a select rise for a given count of falls
	function automatic dapc_mode_t next_mode(input dapc_mode_t m,
		input logic [`DAPC_CNT_W-1:0] n);
		dapc_mode_t r;
		r = m;
		if (n < `DAPC_WIN_LO)
			r = m;
		else if (n < `DAPC_WIN_HI)
		begin
			if (m == DAPC_NORMAL)
				r = DAPC_PARTIAL;
			else
				r = DAPC_FULL;
		end
		else
			r = DAPC_NORMAL;
		return r;
	endfunction
	// clamp a result into the code range
	function automatic logic [`DAPC_RES_W-1:0] clamp(
		input logic [`DAPC_RES_W-1:0] v);
		return (v > `DAPC_CODE_MAX) ? `DAPC_CODE_MAX : v;
	endfunction
	// shift word: second zero, result msb first, first trailing zero
	function automatic logic [15:0] frame_word(
		input logic [`DAPC_RES_W-1:0] v);
		return {1'b0, v, 1'b0};
	endfunction
	// result buffer between converter and serial engine
	assign fifo_in.res_a = clamp(converter_a);
	assign fifo_in.res_b = clamp(converter_b);
	dapc_fifo #(
		.WIDTH (`DAPC_FIFO_W),
		.DEPTH (`DAPC_FIFO_DEPTH),
		.AW    (`DAPC_FIFO_AW)
	) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (conv_valid),
		.in_ready  (conv_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_out)
	);
	// edge detection on the second synchroniser stage onward
	assign cs_fall   = s_q.cs_sync[2] && !s_q.cs_sync[1];
	assign cs_rise   = !s_q.cs_sync[2] && s_q.cs_sync[1];
	assign sclk_fall = s_q.sclk_sync[2] && !s_q.sclk_sync[1];
	assign sclk_rise = !s_q.sclk_sync[2] && s_q.sclk_sync[1];
	assign pop       = cs_fall && fifo_valid;
	// result at the buffer head, zeros when the buffer is empty
	assign head      = fifo_valid ? fifo_out : '0;
	// frame engine and power mode sequencing
	always_comb
	begin
		s_d = s_q;
		s_d.cs_sync   = {s_q.cs_sync[1:0], cs_n};
		s_d.sclk_sync = {s_q.sclk_sync[1:0], sclk};
		s_d.start     = 1'b0;
		if (cs_fall)
		begin
			// sample both channels, drive bus, first zero
			s_d.active      = 1'b1;
			s_d.falls       = '0;
			s_d.hold        = 1'b1;
			s_d.start       = 1'b1;
			s_d.wake_pend   = (s_q.mode != DAPC_NORMAL);
			s_d.valid_frame = fifo_valid;
			s_d.sh_a        = frame_word(head.res_a);
			s_d.sh_b        = frame_word(head.res_b);
			s_d.nxt_a       = head.res_b;
			s_d.nxt_b       = head.res_a;
			s_d.oa          = 1'b0;
			s_d.ob          = 1'b0;
			s_d.oea         = 1'b1;
			s_d.oeb         = 1'b1;
		end
		else if (cs_rise && s_q.active)
		begin
			// end conversion, float, settle mode
			s_d.active     = 1'b0;
			s_d.oea        = 1'b0;
			s_d.oeb        = 1'b0;
			s_d.hold       = 1'b0;
			s_d.track_pend = 1'b0;
			s_d.wake_pend  = 1'b0;
			s_d.mode       = next_mode(s_q.mode, s_q.falls);
		end
		else if (s_q.active)
		begin
			// serial clock paces conversion and shifting
			if (sclk_rise && s_q.wake_pend)
			begin
				s_d.hold      = 1'b0;
				s_d.wake_pend = 1'b0;
			end
			if (sclk_rise && s_q.track_pend)
			begin
				s_d.hold       = 1'b0;
				s_d.track_pend = 1'b0;
			end
			if (sclk_fall)
			begin
				if (s_q.falls != '1)
					s_d.falls = s_q.falls + 1'b1;
				if (s_q.falls + 1'b1 == `DAPC_TRACK_EDGE)
					s_d.track_pend = 1'b1;
				// msb first, then trailing zeros
				s_d.oa   = s_q.sh_a[15];
				s_d.ob   = s_q.sh_b[15];
				s_d.sh_a = {s_q.sh_a[14:0], 1'b0};
				s_d.sh_b = {s_q.sh_b[14:0], 1'b0};
				if (s_q.falls + 1'b1 == `DAPC_FRAME_LEN)
				begin
					// swap channels for single-line readout
					s_d.sh_a = frame_word(s_q.nxt_a);
					s_d.sh_b = frame_word(s_q.nxt_b);
				end
				if (s_q.falls + 1'b1 == `DAPC_DUAL_LEN)
				begin
					s_d.oea = 1'b0;
					s_d.oeb = 1'b0;
				end
			end
		end
		if (!rst_n)
		begin
			s_d.active      = 1'b0;
			s_d.falls       = '0;
			s_d.track_pend  = 1'b0;
			s_d.wake_pend   = 1'b0;
			s_d.hold        = 1'b0;
			s_d.valid_frame = 1'b0;
			s_d.sh_a        = '0;
			s_d.sh_b        = '0;
			s_d.nxt_a       = '0;
			s_d.nxt_b       = '0;
			s_d.oa          = 1'b0;
			s_d.ob          = 1'b0;
			s_d.oea         = 1'b0;
			s_d.oeb         = 1'b0;
			s_d.start       = 1'b0;
			s_d.mode        = DAPC_NORMAL;
			s_d.cs_sync     = 3'h7;
			s_d.sclk_sync   = 3'h7; // link clock idles high: no false edge
		end
		// power flags follow the settled mode
		s_d.pwr    = (s_d.mode == DAPC_NORMAL);
		s_d.ref_en = (s_d.mode != DAPC_FULL);
	end
	// state register
	always_ff @(posedge mclk)
	begin
		s_q <= s_d;
	end
	// outputs straight from state flops
	assign serial_out_a    = s_q.oa;
	assign serial_out_b    = s_q.ob;
	assign serial_out_a_oe = s_q.oea;
	assign serial_out_b_oe = s_q.oeb;
	assign sample_hold     = s_q.hold;
	assign conv_start      = s_q.start;
	assign powered         = s_q.pwr;
	assign ref_on          = s_q.ref_en;
	assign mode            = s_q.mode;
endmodule // dapc_top

/* File: verilog/dapc_defines.svh */
`ifndef DAPC_DEFINES_SVH
`define DAPC_DEFINES_SVH
// Operation
// - early rise from normal: abort, partial down
// - two early rises in row: full down
// - early rise while partial: full down
// - power-down needs no remaining frame clocks
// - full wake: long dummy, then wait
// - waking hold returns track first edge
// - serial clock times conversion and data
// - select fall samples both, outputs drive
// - track again after fifteenth falling edge
// - select rise ends conversion, outputs float
// - extended frame swaps channel results across outputs
// - float at 32nd fall or rise
// - two zeros, fourteen bits msb first
// - rise before second edge keeps mode
// - rise after tenth edge keeps power
// - two trailing zeros after result
// - result codes span 0 to 16383
`define DAPC_RES_W        14
`define DAPC_CNT_W        6
`define DAPC_WIN_LO       6'h02
`define DAPC_WIN_HI       6'h0A
`define DAPC_TRACK_EDGE   6'h0F
`define DAPC_FRAME_LEN    6'h10
`define DAPC_DUAL_LEN     6'h20
`define DAPC_CODE_MAX     14'h3FFF
`define DAPC_FIFO_DEPTH   16
`define DAPC_FIFO_AW      4
`define DAPC_FIFO_W       28
`endif

/* File: verilog/dapc_pkg.sv */
`include "dapc_defines.svh"
package dapc_pkg;
	typedef enum logic [2:0]
	{
		DAPC_NORMAL  = 3'b001,
		DAPC_PARTIAL = 3'b010,
		DAPC_FULL    = 3'b100
	} dapc_mode_t;
	typedef struct packed
	{
		logic [`DAPC_RES_W-1:0] res_a;
		logic [`DAPC_RES_W-1:0] res_b;
	} dapc_pair_t;
endpackage

/* File: verilog/dapc_fifo.sv */
`include "dapc_defines.svh"
module dapc_fifo
#(
	parameter int WIDTH = `DAPC_FIFO_W,
	parameter int DEPTH = `DAPC_FIFO_DEPTH,
	parameter int AW    = `DAPC_FIFO_AW
)
(
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} dapc_fifo_st_t;
	dapc_fifo_st_t s_q;
	dapc_fifo_st_t s_d;
	logic          push;
	logic          pop;
	// honest full and empty from the count
	assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	// pointer and storage update
	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop)
			s_d.rp = s_q.rp + 1'b1;
		if (push && !pop)
			s_d.cnt = s_q.cnt + 1'b1;
		else if (pop && !push)
			s_d.cnt = s_q.cnt - 1'b1;
		if (!rst_n)
		begin
			s_d.wp  = '0;
			s_d.rp  = '0;
			s_d.cnt = '0;
		end
	end
	// state register
	always_ff @(posedge mclk)
	begin
		s_q <= s_d;
	end
endmodule // dapc_fifo

/* File: bench/dapc_top_properties.sv */
module dapc_top_properties
	import dapc_pkg::*;
(
	// clock and reset
	input wire logic       mclk,
	input wire logic       rst_n,
	// watched pins
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic       serial_out_a_oe,
	input wire logic       serial_out_b_oe,
	input wire logic       conv_start,
	input wire logic       sample_hold,
	input wire logic       powered,
	input wire logic       ref_on,
	input wire logic [2:0] mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] nfall_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// falls of the link clock seen inside the current frame
	always_ff @(posedge mclk)
	begin
		if (!rst_n || cs_n)
			nfall_q <= 6'h00;
		else if ($fell(sclk) && nfall_q != 6'h3F)
			nfall_q <= nfall_q + 6'h01;
	end
	// hold stands through a normal frame until the fifteenth fall
	property p_hold_keep;
		!cs_n && !$past(cs_n, 4) && mode == DAPC_NORMAL && nfall_q < 6'h0F
			|-> sample_hold;
	endproperty
	a_hold_keep: assert property (p_hold_keep)
		else $error("hold released before fifteenth fall");
	// track again on the rise after the fifteenth fall
	property p_track;
		$rose(sclk) && !cs_n && mode == DAPC_NORMAL && nfall_q == 6'h0F
			|-> ##3 !sample_hold;
	endproperty
	a_track: assert property (p_track)
		else $error("no track after fifteenth fall");
	// waking from partial: track on the first link clock rise
	property p_wake_track;
		$rose(sclk) && !cs_n && mode == DAPC_PARTIAL |-> ##3 !sample_hold;
	endproperty
	a_wake_track: assert property (p_wake_track)
		else $error("hold kept while waking");
	// outputs drive soon after select falls
	property p_oe_on;
		$fell(cs_n) |-> ##[3:6] serial_out_a_oe && serial_out_b_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("outputs not driven after select fall");
	// outputs float soon after select rises
	property p_oe_off;
		$rose(cs_n) |-> ##[2:6] !serial_out_a_oe && !serial_out_b_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("outputs still driven after select rise");
	property p_start;
		conv_start |=> !conv_start;
	endproperty
	a_start: assert property (p_start)
		else $error("start pulse too long");
	property p_hold;
		conv_start |-> sample_hold;
	endproperty
	a_hold: assert property (p_hold)
		else $error("no hold at sampling");
	// mode moves only once select is high again
	property p_mode;
		$changed(mode) |-> cs_n && $past(cs_n);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode changed inside frame");
	property p_pwr;
		powered == (mode == DAPC_NORMAL);
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("powered flag wrong");
	property p_ref;
		ref_on == (mode != DAPC_FULL);
	endproperty
	a_ref: assert property (p_ref)
		else $error("reference flag wrong");
	property p_pair;
		serial_out_a_oe == serial_out_b_oe;
	endproperty
	a_pair: assert property (p_pair)
		else $error("output enables differ");
	// full power-down is only reached from partial
	property p_step;
		mode == DAPC_FULL && $past(mode) != DAPC_FULL
			|-> $past(mode) == DAPC_PARTIAL;
	endproperty
	a_step: assert property (p_step)
		else $error("full mode not entered from partial");
endmodule // dapc_top_properties
bind dapc_top dapc_top_properties u_props (.mclk, .rst_n, .cs_n, .sclk,
	.serial_out_a_oe, .serial_out_b_oe, .conv_start, .sample_hold,
	.powered, .ref_on, .mode);

/* File: bench/dapc_host.sv */
module dapc_host
(
	// clock
	input wire logic mclk,
	// host pins
	output logic     cs_n,
	output logic     sclk,
	// data lines
	input wire logic serial_out_a,
	input wire logic serial_out_a_oe,
	input wire logic serial_out_b,
	input wire logic serial_out_b_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] samp[$];
	// link clock stands high between frames
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b1;
	end
	// one frame of n falling edges, sampled late in each bit
	task automatic frame(input int n);
		samp = {};
		@(posedge mclk) cs_n <= 1'b0;
		repeat (8) @(posedge mclk);
		for (int i = 0; i < n; i++)
		begin
			samp.push_back({serial_out_a_oe, serial_out_a, serial_out_b});
			sclk <= 1'b0;
			repeat (4) @(posedge mclk);
			sclk <= 1'b1;
			repeat (4) @(posedge mclk);
		end
		samp.push_back({serial_out_a_oe, serial_out_a, serial_out_b});
		cs_n <= 1'b1;
		repeat (12) @(posedge mclk);
	endtask
endmodule // dapc_host

/* File: bench/dapc_top_tb.sv */
module dapc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, rst_n = 0, conv_valid = 0;
	logic [13:0] converter_a = 0, converter_b = 0;
	logic        cs_n, sclk, conv_ready, sample_hold, conv_start;
	logic        serial_out_a, serial_out_a_oe, powered, ref_on;
	logic        serial_out_b, serial_out_b_oe;
	logic [2:0]  mode;
	logic [31:0] lf = 32'hDFC2640F;
	logic [27:0] q[$];
	int          n_mismatch = 0, n_checks = 0, cyc = 0, md = 0;
	// falls per frame, dummies and wakes
	int lens[16] = '{20, 1, 5, 1, 5, 12, 32, 40, 9, 10, 16, 2, 3, 16, 33, 17};
	always #20 mclk = ~mclk;
	dapc_top uut (.mclk, .rst_n, .cs_n, .sclk, .serial_out_a,
		.serial_out_a_oe, .serial_out_b, .serial_out_b_oe, .conv_valid,
		.conv_ready, .converter_a, .converter_b, .sample_hold, .conv_start,
		.powered, .ref_on, .mode);
	dapc_host host (.mclk, .cs_n, .sclk, .serial_out_a, .serial_out_a_oe,
		.serial_out_b, .serial_out_b_oe);
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// bit at frame position p: own result first, other after swap
	function automatic logic bv(input logic [13:0] f, s, input int p);
		if (p >= 2 && p < 16) return f[15 - p];
		if (p >= 18 && p < 32) return s[31 - p];
		return 1'b0;
	endfunction
	task automatic chk(input string nm, input logic [2:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hold the word until ready is seen high at an edge
	task automatic push(input logic [27:0] d);
		conv_valid <= 1'b1;
		{converter_a, converter_b} <= d;
		do @(negedge mclk); while (conv_ready !== 1'b1);
		@(posedge mclk);
		q.push_back(d);
	endtask
	task automatic frame(input int n);
		logic [27:0] d;
		logic [2:0]  e;
		d = q.size() ? q.pop_front() : 28'h0;
		host.frame(n);
		for (int p = 0; p <= n; p++)
		begin
			e = p < 32 ? {1'b1, bv(d[27:14], d[13:0], p),
				bv(d[13:0], d[27:14], p)} : {1'b0, host.samp[p][1:0]};
			chk("bits", host.samp[p], e);
		end
		md = n >= 10 ? 0 : n < 2 ? md : md == 0 ? 1 : 2;
		chk("mode", mode, 3'b001 << md);
		$display("frame of %0d falls done", n);
	endtask
	// cut a hang short
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_mismatch++;
			results;
		end
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		push(28'h0);
		push(28'hFFFFFFF);
		repeat (14)
		begin
			lf = step(lf);
			push(lf[27:0]);
		end
		conv_valid <= 1'b0;
		@(negedge mclk);
		chk("fifo full", {2'b00, conv_ready}, 3'b000);
		foreach (lens[i]) frame(lens[i]);
		results;
	end
endmodule // dapc_top_tb
